// [lusf_cfg.svh]
// Purpose: offsets, field positions, reset values of the stream framer
// Assumes: 32-bit register words at byte addresses
// Notes: included by the framer and its testbench
`ifndef LUSF_CFG_SVH
`define LUSF_CFG_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LUSF_ADDR_CTRL 8'h00
`define LUSF_ADDR_RATE 8'h04
`define LUSF_ADDR_PORT 8'h08
`define LUSF_ADDR_STAT 8'h0C
`define LUSF_ADDR_IP 8'h10
// ----------------------------------------------------------------
// control and rate fields
// ----------------------------------------------------------------
`define LUSF_CTRL_EN 0
`define LUSF_CTRL_LE 1
`define LUSF_CTRL_CK 2
`define LUSF_CTRL_CONT 4
`define LUSF_CTRL_SIZE 8
`define LUSF_RATE_SUB 8
// ----------------------------------------------------------------
// header fields, reset values and limits
// ----------------------------------------------------------------
`define LUSF_HDR_LEN 8
`define LUSF_HDR_CONT 12
`define LUSF_HDR_RATE 16
`define LUSF_HDR_OVL 24
`define LUSF_HDR_ERR 25
`define LUSF_HDR_LE 28
`define LUSF_HDR_CK 29
`define LUSF_PORT_RST 16'h0749
`define LUSF_MAX_RATE 5'h1F
`define LUSF_FULL_LEN 11'h400
`endif

// [lusf_pkg.sv]
// Purpose: types of the stream framer
// Assumes: nothing
// Notes: constants live in lusf_cfg.svh
package lusf_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_DATA, ST_WAIT} lusf_state_e;
  typedef struct packed {
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] r;
    logic [31:0] th;
  } lusf_sample_s;
  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
  } lusf_byte_s;
  typedef struct packed {
    logic in_ovld;
    logic sync_on;
    logic sync_ovld;
    logic out_ovld;
    logic pll_unlock;
    logic sync_oor;
  } lusf_status_s;
endpackage

// [lusf_framer.sv]
// Purpose: builds stream packet payloads (header word plus sample bytes)
// Assumes: samples, status and byte sink share clk; ip/udp stack outside
// Notes: one byte per cycle, 40 MB/s peak
`timescale 1ns/10ps
`include "lusf_cfg.svh"
module lusf_framer
  import lusf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] cmd_src_ip,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire lusf_sample_s sample,
  input wire lusf_status_s status,
  output logic out_valid,
  input wire logic out_ready,
  output lusf_byte_s out_byte,
  output logic [31:0] dest_ip,
  output logic [15:0] dest_port
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] comp_word(lusf_sample_s s,
                                            logic [1:0] cont,
                                            logic [1:0] ci);
    logic [31:0] w;
    w = s.x;
    unique case (cont)
      2'h0: w = s.x;
      2'h1: w = ci[0] ? s.y : s.x;
      2'h2: w = ci[0] ? s.th : s.r;
      2'h3: w = ci[1] ? (ci[0] ? s.th : s.r) : (ci[0] ? s.y : s.x);
    endcase
    return w;
  endfunction

  // byte k in emission order of a component of 2 or 4 bytes
  function automatic logic [7:0] pick_byte(logic [31:0] w, logic is_int,
                                           logic le, logic [1:0] k);
    logic [1:0] top;
    logic [1:0] sel;
    top = is_int ? 2'h1 : 2'h3;
    sel = le ? k : 2'(top - k);
    return w[8*sel +: 8];
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] rate_r, rate_nxt;
  logic [15:0] port_r, port_nxt;
  logic [31:0] ip_r, ip_nxt;
  logic [31:0] rdata_nxt;
  logic busy;
  logic [7:0] pcnt_r;
  logic stream_start_cmd;
  logic [4:0] sub_exp;
  logic [5:0] rate_sum;
  logic [4:0] eff_rate;

  assign stream_start_cmd = reg_wr && reg_addr == `LUSF_ADDR_CTRL &&
                            reg_wdata[`LUSF_CTRL_EN] &&
                            !ctrl_r[`LUSF_CTRL_EN];
  assign sub_exp = rate_r[`LUSF_RATE_SUB +: 5];
  assign rate_sum = {1'b0, rate_r[4:0]} + {1'b0, sub_exp};
  assign eff_rate = rate_sum[5] ? `LUSF_MAX_RATE : rate_sum[4:0];

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    rate_nxt = rate_r;
    port_nxt = port_r;
    ip_nxt = ip_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `LUSF_ADDR_CTRL: ctrl_nxt = reg_wdata & 32'h0000_0377;
        `LUSF_ADDR_RATE: rate_nxt = reg_wdata & 32'h0000_1F1F;
        `LUSF_ADDR_PORT: port_nxt = reg_wdata[15:0];
        default: ;
      endcase
    end
    if (stream_start_cmd)
      ip_nxt = cmd_src_ip;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `LUSF_ADDR_CTRL: rdata_nxt = ctrl_r;
        `LUSF_ADDR_RATE: rdata_nxt = rate_r;
        `LUSF_ADDR_PORT: rdata_nxt = {16'h0000, port_r};
        `LUSF_ADDR_STAT: rdata_nxt = {15'h0000, busy, 3'h0, eff_rate,
                                      pcnt_r};
        `LUSF_ADDR_IP: rdata_nxt = ip_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r <= 32'h0000_0000;
      rate_r <= 32'h0000_0000;
      port_r <= `LUSF_PORT_RST;
      ip_r <= 32'h0000_0000;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      rate_r <= rate_nxt;
      port_r <= port_nxt;
      ip_r <= ip_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  assign dest_ip = ip_r;
  assign dest_port = port_r;

  // ----------------------------------------------------------------
  // framing engine
  // ----------------------------------------------------------------
  lusf_state_e st_r, st_nxt;
  lusf_sample_s smp_r, smp_nxt;
  logic [31:0] hdr_r, hdr_nxt;
  logic [7:0] pcnt_nxt;
  logic [1:0] hb_r, hb_nxt;
  logic [1:0] ci_r, ci_nxt;
  logic [1:0] bi_r, bi_nxt;
  logic [10:0] bc_r, bc_nxt;
  logic [31:0] sub_r, sub_nxt;
  logic ov_r, ov_nxt;
  lusf_byte_s ob_r, ob_nxt;
  logic keep, need, take, adv;
  logic is_int, le;
  logic [1:0] cont, nc_m1, bpc_m1;
  logic [10:0] size_m1;
  logic [31:0] sub_mask;
  logic ovl, err;

  assign cont = hdr_r[`LUSF_HDR_CONT +: 2];
  assign is_int = hdr_r[`LUSF_HDR_CONT + 2];
  assign le = hdr_r[`LUSF_HDR_LE];
  assign nc_m1 = (cont == 2'h3) ? 2'h3 : ((cont == 2'h0) ? 2'h0 : 2'h1);
  assign bpc_m1 = is_int ? 2'h1 : 2'h3;
  assign size_m1 = 11'((`LUSF_FULL_LEN >> hdr_r[`LUSF_HDR_LEN +: 2]) - 1);
  assign sub_mask = 32'((64'h1 << sub_exp) - 64'h1);
  assign keep = (sub_r & sub_mask) == 32'h0000_0000;
  assign need = (st_r == ST_IDLE && ctrl_r[`LUSF_CTRL_EN]) ||
                st_r == ST_WAIT;
  assign sample_ready = !keep || need;
  assign take = sample_valid && sample_ready && keep;
  assign adv = !ov_r || out_ready;
  assign busy = st_r != ST_IDLE;
  assign ovl = status.in_ovld || (status.sync_on && status.sync_ovld) ||
               (ctrl_r[`LUSF_CTRL_CONT + 2] && status.out_ovld);
  assign err = status.pll_unlock || status.sync_oor;

  always_comb
  begin
    st_nxt = st_r;
    smp_nxt = smp_r;
    hdr_nxt = hdr_r;
    pcnt_nxt = pcnt_r;
    hb_nxt = hb_r;
    ci_nxt = ci_r;
    bi_nxt = bi_r;
    bc_nxt = bc_r;
    ob_nxt = ob_r;
    ov_nxt = ov_r && !out_ready;
    sub_nxt = sub_r;
    if (sample_valid && sample_ready)
      sub_nxt = (sub_r + 32'h0000_0001) & sub_mask;
    unique case (st_r)
      ST_IDLE:
        if (take)
        begin
          smp_nxt = sample;
          hdr_nxt = 32'h0000_0000;
          hdr_nxt[7:0] = pcnt_r;
          hdr_nxt[`LUSF_HDR_LEN +: 4] =
            {2'h0, ctrl_r[`LUSF_CTRL_SIZE +: 2]};
          hdr_nxt[`LUSF_HDR_CONT +: 4] =
            {1'b0, ctrl_r[`LUSF_CTRL_CONT +: 3]};
          hdr_nxt[`LUSF_HDR_RATE +: 8] = {3'h0, eff_rate};
          hdr_nxt[`LUSF_HDR_OVL] = ovl;
          hdr_nxt[`LUSF_HDR_ERR] = err;
          hdr_nxt[`LUSF_HDR_LE] = ctrl_r[`LUSF_CTRL_LE];
          hdr_nxt[`LUSF_HDR_CK] = ctrl_r[`LUSF_CTRL_CK];
          hb_nxt = 2'h0;
          st_nxt = ST_HDR;
        end
      ST_HDR:
        if (adv)
        begin
          ov_nxt = 1'b1;
          ob_nxt.data = hdr_r[8*(2'h3 - hb_r) +: 8];
          ob_nxt.first = hb_r == 2'h0;
          ob_nxt.last = 1'b0;
          hb_nxt = 2'(hb_r + 2'h1);
          if (hb_r == 2'h3)
          begin
            ci_nxt = 2'h0;
            bi_nxt = 2'h0;
            bc_nxt = 11'h000;
            st_nxt = ST_DATA;
          end
        end
      ST_DATA:
        if (adv)
        begin
          ov_nxt = 1'b1;
          ob_nxt.data = pick_byte(comp_word(smp_r, cont, ci_r), is_int,
                                  le, bi_r);
          ob_nxt.first = 1'b0;
          ob_nxt.last = bc_r == size_m1;
          bc_nxt = 11'(bc_r + 11'h001);
          bi_nxt = 2'(bi_r + 2'h1);
          if (bi_r == bpc_m1)
          begin
            bi_nxt = 2'h0;
            ci_nxt = 2'(ci_r + 2'h1);
            if (ci_r == nc_m1)
            begin
              ci_nxt = 2'h0;
              if (bc_r == size_m1)
              begin
                pcnt_nxt = 8'(pcnt_r + 8'h01);
                st_nxt = ST_IDLE;
              end
              else
                st_nxt = ST_WAIT;
            end
          end
        end
      ST_WAIT:
        if (take)
        begin
          smp_nxt = sample;
          st_nxt = ST_DATA;
        end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= ST_IDLE;
      smp_r <= '0;
      hdr_r <= 32'h0000_0000;
      pcnt_r <= 8'h00;
      hb_r <= 2'h0;
      ci_r <= 2'h0;
      bi_r <= 2'h0;
      bc_r <= 11'h000;
      sub_r <= 32'h0000_0000;
      ov_r <= 1'b0;
      ob_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      smp_r <= smp_nxt;
      hdr_r <= hdr_nxt;
      pcnt_r <= pcnt_nxt;
      hb_r <= hb_nxt;
      ci_r <= ci_nxt;
      bi_r <= bi_nxt;
      bc_r <= bc_nxt;
      sub_r <= sub_nxt;
      ov_r <= ov_nxt;
      ob_r <= ob_nxt;
    end
  end

  assign out_valid = ov_r;
  assign out_byte = ob_r;
endmodule

// [lusf_framer_assertions.sv]
// Purpose: port checks for the stream framer
// Assumes: one clock, async low reset
// Notes: bound to lusf_framer
`timescale 1ns/10ps
module lusf_framer_chk
  import lusf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire lusf_byte_s out_byte,
  input wire logic [15:0] dest_port
);
  logic [10:0] cnt_r;
  logic [7:0] pc_r;
  logic seen_r;
  wire acc = out_valid && out_ready;
  // byte index within packet, last counter value seen
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt_r <= 11'h000;
      pc_r <= 8'h00;
      seen_r <= 1'b0;
    end
    else if (acc)
    begin
      cnt_r <= out_byte.last ? 11'h000 : cnt_r + 11'h001;
      if (cnt_r == 11'h003)
      begin
        pc_r <= out_byte.data;
        seen_r <= 1'b1;
      end
    end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_first;
    acc && out_byte.first |-> cnt_r == 11'h000;
  endproperty
  a_first: assert property (p_first)
    else $error("first flag away from packet start");
  property p_len;
    acc && out_byte.last |-> cnt_r inside {11'h083, 11'h103, 11'h203, 11'h403};
  endproperty
  a_len: assert property (p_len)
    else $error("packet length not header plus size");
  property p_next;
    acc && out_byte.last |=> !out_valid || out_byte.first;
  endproperty
  a_next: assert property (p_next)
    else $error("byte after last is not a header start");
  property p_rate;
    acc && cnt_r == 11'h001 |-> out_byte.data[7:5] == 3'h0;
  endproperty
  a_rate: assert property (p_rate)
    else $error("rate code above 31");
  property p_codes;
    acc && cnt_r == 11'h002 |->
      !out_byte.data[7] && out_byte.data[3:2] == 2'h0;
  endproperty
  a_codes: assert property (p_codes)
    else $error("content or length code out of range");
  property p_pkt_cnt;
    acc && cnt_r == 11'h003 && seen_r |-> out_byte.data == pc_r + 8'h01;
  endproperty
  a_pkt_cnt: assert property (p_pkt_cnt)
    else $error("packet counter skipped");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_byte);
  endproperty
  a_hold: assert property (p_hold)
    else $error("byte changed before acceptance");
  property p_port;
    $rose(rst_b) |-> dest_port == 16'h0749;
  endproperty
  a_port: assert property (p_port)
    else $error("destination port reset value wrong");
  c_last: cover property (acc && out_byte.last);
  c_cnt: cover property (acc && cnt_r == 11'h003 && seen_r);
  c_stall: cover property (out_valid && !out_ready);
endmodule
bind lusf_framer lusf_framer_chk u_lusf_framer_chk (.clk(clk),
  .rst_b(rst_b), .out_valid(out_valid), .out_ready(out_ready),
  .out_byte(out_byte), .dest_port(dest_port));

// [lusf_sink_model.sv]
// Purpose: receiving host, collects payload bytes
// Assumes: slow high makes it stall at random
// Notes: bytes kept in wire order
`timescale 1ns/10ps
module lusf_sink_model
  import lusf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic out_valid,
  input wire lusf_byte_s out_byte,
  output logic out_ready
);
  lusf_byte_s rx_q[$];
  int pkts = 0;
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
      out_ready <= 1'b0;
    else
    begin
      if (out_valid && out_ready)
      begin
        rx_q.push_back(out_byte);
        if (out_byte.last)
          pkts++;
      end
      out_ready <= !slow || ($urandom % 3 != 0);
    end
endmodule

// [lusf_framer_tb.sv]
// Purpose: self-checking bench of the stream framer
// Assumes: sink model stands for the receiving host
// Notes: one packet per content code, sizes and byte orders rotate
`timescale 1ns/10ps
`include "lusf_cfg.svh"
module lusf_framer_tb
  import lusf_pkg::*;
;
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, sample_valid = 0;
  logic slow = 0, sample_ready, out_valid, out_ready;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, cmd_src_ip = 0, dest_ip;
  logic [15:0] dest_port;
  lusf_sample_s sample = '0;
  lusf_status_s status = '0;
  lusf_byte_s out_byte;
  int miscompares = 0, checked = 0, cyc = 0;
  always #12.5 clk = ~clk;
  lusf_framer u_lusf_framer (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_src_ip(cmd_src_ip),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample(sample), .status(status), .out_valid(out_valid),
    .out_ready(out_ready), .out_byte(out_byte), .dest_ip(dest_ip),
    .dest_port(dest_port));
  lusf_sink_model u_lusf_sink_model (.clk(clk), .rst_b(rst_b), .slow(slow),
    .out_valid(out_valid), .out_byte(out_byte), .out_ready(out_ready));
  task finish_test;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] wire_byte(input logic [31:0] v, input int w,
                                           input logic le, input int k);
    return v[8*(le ? k : w - 1 - k) +: 8];
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  task send(input lusf_sample_s v);
    sample <= v;
    sample_valid <= 1'b1;
    do @(negedge clk); while (!sample_ready);
    @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      finish_test();
    end
  end
  initial
  begin
    logic [4:0] sub, rt;
    logic [31:0] ip, hd, cv[4];
    logic [3:0] cm;
    logic ovl;
    int w, nk;
    lusf_sample_s s;
    logic [7:0] q[$];
    lusf_byte_s r[$];
    void'($urandom(85));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd(`LUSF_ADDR_PORT, 32'h0000_0749);
    wr(`LUSF_ADDR_PORT, 32'h0000_1234);
    rd(`LUSF_ADDR_PORT, 32'h0000_1234);
    chk(dest_port, 32'h0000_1234);
    rd(8'h14, 32'h0000_0000);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      sub = (i == 7) ? 5'h02 : 5'(i % 2);
      rt = (i == 7) ? 5'h1E : 5'($urandom % 31);
      slow <= i[0];
      status <= 6'($urandom);
      ip = $urandom;
      cmd_src_ip <= ip;
      wr(`LUSF_ADDR_RATE, {19'h0, sub, 3'h0, rt});
      hd = {22'h0, i[1:0], 1'b0, i[2:0], 1'b0, i[1], i[0] ^ i[2], 1'b0};
      wr(`LUSF_ADDR_CTRL, hd);
      wr(`LUSF_ADDR_CTRL, hd | 32'h0000_0001);
      rt = (rt + sub > 31) ? 5'h1F : 5'(rt + sub);
      ovl = status.in_ovld | (status.sync_on & status.sync_ovld) |
        (i[2] & status.out_ovld);
      hd = {2'h0, i[1], i[0] ^ i[2], 2'h0, status.pll_unlock | status.sync_oor,
        ovl, 3'h0, rt, 1'b0, i[2:0], 2'h0, i[1:0], i[7:0]};
      w = i[2] ? 2 : 4;
      cm = (i % 4 == 0) ? 4'h1 : (i % 4 == 1) ? 4'h3 :
        (i % 4 == 2) ? 4'hC : 4'hF;
      nk = (1024 >> i[1:0]) / (w * $countones(cm));
      q = {};
      for (int k = 3; k >= 0; k--)
        q.push_back(hd[8*k +: 8]);
      for (int j = 0; j < nk; j++)
      begin
        s = {$urandom, $urandom, $urandom, $urandom};
        cv = '{s.x, s.y, s.r, s.th};
        for (int c = 0; c < 4; c++)
          for (int k = 0; k < w; k++)
            if (cm[c])
              q.push_back(wire_byte(cv[c], w, hd[28], k));
        // only the first of each group may reach the packet
        send(s);
        repeat ((1 << sub) - 1)
          send({$urandom, $urandom, $urandom, $urandom});
      end
      sample_valid <= 1'b0;
      while (u_lusf_sink_model.rx_q.size() < q.size())
        @(posedge clk);
      r = u_lusf_sink_model.rx_q;
      chk(r[0], {q[0], 2'h2});
      chk(r[1], {q[1], 2'h0});
      chk(r[2], {q[2], 2'h0});
      chk(r[3], {q[3], 2'h0});
      for (int k = 4; k < q.size(); k++)
        chk(r[k], {q[k], 1'b0, k == q.size() - 1});
      chk(u_lusf_sink_model.pkts, i + 1);
      u_lusf_sink_model.rx_q.delete();
      rd(`LUSF_ADDR_IP, ip);
      chk(dest_ip, ip);
      rd(`LUSF_ADDR_STAT, {19'h0, rt, 8'(i + 1)});
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule
